// file: rtl/acrb_defines.vh
// Purpose: constants for the converter configuration register bank
// Assumes: byte-wide register port, byte addresses
// Notes: every register is four byte locations, bits 7-0 at the base address
`ifndef ACRB_DEFINES_VH
`define ACRB_DEFINES_VH

// -----------------------------------------------------------------------------
// register base byte addresses
// -----------------------------------------------------------------------------
`define ACRB_ADDR_W 6
`define ACRB_OFS_DEVICE_IDENTIFICATION 6'h00
`define ACRB_OFS_RESET_POWER_CONTROL 6'h04
`define ACRB_OFS_INPUT_PROTOCOL_CONTROL 6'h08
`define ACRB_OFS_OUTPUT_PROTOCOL_CONTROL 6'h0C
`define ACRB_OFS_OUTPUT_DATA_CONTROL 6'h10
`define ACRB_OFS_INPUT_RANGE_SELECT 6'h14
`define ACRB_OFS_ALARM_OUTPUT 6'h20
`define ACRB_OFS_ALARM_HIGH_THRESHOLD 6'h24
`define ACRB_OFS_ALARM_LOW_THRESHOLD 6'h28

// -----------------------------------------------------------------------------
// byte locations of fields
// -----------------------------------------------------------------------------
`define ACRB_LOC_DEVICE_ADDR 6'h02
`define ACRB_LOC_CTRL_LOW 6'h04
`define ACRB_LOC_UNLOCK_KEY 6'h05
`define ACRB_LOC_PROTOCOL 6'h08

// -----------------------------------------------------------------------------
// field positions and values
// -----------------------------------------------------------------------------
`define ACRB_BIT_SUPPLY_ALARM_DIS 5
`define ACRB_BIT_INPUT_ALARM_DIS 4
`define ACRB_BIT_RESET_PIN_CLASS 2
`define ACRB_BIT_LIGHT_SLEEP_EN 1
`define ACRB_BIT_SHUTDOWN 0
`define ACRB_UNLOCK_VALUE 8'h69
`define ACRB_DEVICE_ADDR_RST 4'h0
`define ACRB_KEY_RST 8'h00
`define ACRB_PROTOCOL_RST 2'h0
`define ACRB_BYTE_RST 8'h00
`define ACRB_READ_LATENCY 2

`endif

// file: rtl/acrb_byte_store.v
// Purpose: byte store for the registers kept as plain data
// Assumes: one write port, one read port, read data registered
// Notes: clear wipes every byte in one cycle
`include "acrb_defines.vh"
`default_nettype none

module acrb_byte_store #(
  parameter DEPTH = 24,
  parameter AW = 5
) (
  input wire clk,
  input wire clr,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data_r
);

  reg [7:0] mem_r [0:DEPTH-1];
  integer i;

  // -----------------------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (clr) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= `ACRB_BYTE_RST;
      end
      rd_data_r <= `ACRB_BYTE_RST;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data_r <= mem_r[rd_addr];
    end
  end

endmodule

`default_nettype wire

// file: rtl/acrb_register_bank.v
// Purpose: configuration register bank of a serial converter
// Assumes: serial front end decodes frames into byte reads and writes
// Notes: srst is the power-on reset; the reset pin arrives asynchronously
`include "acrb_defines.vh"
`default_nettype none

// Behaviour
// - nine 32-bit registers, each four separately addressable bytes.
// - bases 00h,04h,08h,0Ch,10h,14h,20h,24h,28h.
// - bits 7-0 at base, higher bytes at base plus one to three.
// - identification holds 4-bit device address in bits 19-16, resets zero.
// - reserved bits read zero and cannot be written.
// - 8-bit key in bits 15-8; bits 5-0 writable only when key is 69h.
// - bit 5 set disables supply alarm; resets zero.
// - bit 4 set disables input alarm; resets zero.
// - bit 2 clear makes reset pin full init, set makes it application reset.
// - once set, reset-pin class bit stays until power-on reset.
// - bit 1 set lets converter nap when start/select stays high after conversion.
// - bit 0 set requests power-down, clear means active; resets zero.
// - class and nap bits reset only on power-on or full-init pin reset; others also on application reset.
// - byte 08h bits 1-0 hold write protocol select, reset zero.
// - select codes give polarity and phase: 00,01,10,11 map to pol/phase.
module acrb_register_bank (
  input wire clk,
  input wire srst,
  input wire reset_pin_n,
  input wire conversion_start_select,
  input wire conversion_done,
  input wire wr_en,
  input wire [`ACRB_ADDR_W-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire [`ACRB_ADDR_W-1:0] rd_addr,
  output reg [7:0] rd_data_r,
  output reg rd_valid_r,
  output reg [3:0] device_addr_r,
  output reg supply_alarm_disable_r,
  output reg input_alarm_disable_r,
  output reg reset_pin_class_r,
  output reg light_sleep_enable_r,
  output reg shutdown_request_r,
  output reg [1:0] write_protocol_select_r,
  output reg clock_polarity_r,
  output reg clock_phase_r,
  output reg light_sleep_active_r,
  output reg full_init_r,
  output reg app_reset_r
);

  // -----------------------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------------------
  // maps a byte address onto the plain store; bit 5 is the valid flag
  function [5:0] store_index;
    input [`ACRB_ADDR_W-1:0] a;
    begin
      case (a[5:2])
        4'h3: store_index = {1'b1, 3'd0, a[1:0]};
        4'h4: store_index = {1'b1, 3'd1, a[1:0]};
        4'h5: store_index = {1'b1, 3'd2, a[1:0]};
        4'h8: store_index = {1'b1, 3'd3, a[1:0]};
        4'h9: store_index = {1'b1, 3'd4, a[1:0]};
        4'hA: store_index = {1'b1, 3'd5, a[1:0]};
        default: store_index = 6'h00;
      endcase
    end
  endfunction

  function [4:0] store_addr;
    input [5:0] idx;
    begin
      store_addr = {idx[4:2], 2'b00} + {3'b000, idx[1:0]};
    end
  endfunction

  // -----------------------------------------------------------------------------
  // reset pin and start/select synchronisers
  // -----------------------------------------------------------------------------
  reg pin_meta_r;
  reg pin_sync_r;
  reg cs_meta_r;
  reg cs_sync_r;

  always @(posedge clk) begin
    if (srst) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      cs_meta_r <= 1'b0;
      cs_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= reset_pin_n;
      pin_sync_r <= pin_meta_r;
      cs_meta_r <= conversion_start_select;
      cs_sync_r <= cs_meta_r;
    end
  end

  // pin held low keeps the bank in reset for as long as it is held
  wire pin_active = ~pin_sync_r;
  wire pin_full = pin_active & ~reset_pin_class_r;
  wire pin_app = pin_active & reset_pin_class_r;
  wire por_clear = srst | pin_full;
  wire any_clear = por_clear | pin_app;

  // -----------------------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------------------
  reg [7:0] unlock_key_r;
  wire [5:0] wr_idx = store_index(wr_addr);
  wire [5:0] rd_idx = store_index(rd_addr);
  wire key_ok = (unlock_key_r == `ACRB_UNLOCK_VALUE);
  wire ctrl_wr = wr_en & (wr_addr == `ACRB_LOC_CTRL_LOW) & key_ok;

  // fields cleared by both reset kinds
  always @(posedge clk) begin
    if (any_clear) begin
      device_addr_r <= `ACRB_DEVICE_ADDR_RST;
      unlock_key_r <= `ACRB_KEY_RST;
      supply_alarm_disable_r <= 1'b0;
      input_alarm_disable_r <= 1'b0;
      shutdown_request_r <= 1'b0;
      write_protocol_select_r <= `ACRB_PROTOCOL_RST;
    end else if (wr_en) begin
      // only documented field bits are stored; everything else drops
      if (wr_addr == `ACRB_LOC_DEVICE_ADDR) begin
        device_addr_r <= wr_data[3:0];
      end
      if (wr_addr == `ACRB_LOC_UNLOCK_KEY) begin
        unlock_key_r <= wr_data;
      end
      if (ctrl_wr) begin
        supply_alarm_disable_r <= wr_data[`ACRB_BIT_SUPPLY_ALARM_DIS];
        input_alarm_disable_r <= wr_data[`ACRB_BIT_INPUT_ALARM_DIS];
        shutdown_request_r <= wr_data[`ACRB_BIT_SHUTDOWN];
      end
      if (wr_addr == `ACRB_LOC_PROTOCOL) begin
        write_protocol_select_r <= wr_data[1:0];
      end
    end
  end

  // fields that only a power-on class reset clears
  always @(posedge clk) begin
    if (por_clear) begin
      reset_pin_class_r <= 1'b0;
      light_sleep_enable_r <= 1'b0;
    end else if (ctrl_wr) begin
      // the class bit can only be set; clearing waits for a power cycle
      reset_pin_class_r <= reset_pin_class_r | wr_data[`ACRB_BIT_RESET_PIN_CLASS];
      light_sleep_enable_r <= wr_data[`ACRB_BIT_LIGHT_SLEEP_EN];
    end
  end

  // polarity and phase follow the select code directly
  always @(posedge clk) begin
    if (any_clear) begin
      clock_polarity_r <= 1'b0;
      clock_phase_r <= 1'b0;
    end else begin
      clock_polarity_r <= write_protocol_select_r[1];
      clock_phase_r <= write_protocol_select_r[0];
    end
  end

  // -----------------------------------------------------------------------------
  // light sleep
  // -----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (any_clear) begin
      light_sleep_active_r <= 1'b0;
    end else if (~light_sleep_enable_r | ~cs_sync_r) begin
      light_sleep_active_r <= 1'b0;
    end else if (conversion_done) begin
      light_sleep_active_r <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      full_init_r <= 1'b1;
      app_reset_r <= 1'b0;
    end else begin
      full_init_r <= pin_full;
      app_reset_r <= pin_app;
    end
  end

  // -----------------------------------------------------------------------------
  // plain byte store for registers carried as data
  // -----------------------------------------------------------------------------
  wire [7:0] store_rd_data;

  acrb_byte_store #(
    .DEPTH(24),
    .AW(5)
  ) u_store (
    .clk(clk),
    .clr(any_clear),
    .wr_en(wr_en & wr_idx[5]),
    .wr_addr(store_addr(wr_idx)),
    .wr_data(wr_data),
    .rd_addr(store_addr(rd_idx)),
    .rd_data_r(store_rd_data)
  );

  // -----------------------------------------------------------------------------
  // read path, two cycles so both sources line up
  // -----------------------------------------------------------------------------
  reg [7:0] local_byte;
  reg [7:0] local_byte_r;
  reg from_store_r;
  reg rd_pend_r;

  always @* begin
    local_byte = 8'h00;
    case (rd_addr)
      `ACRB_LOC_DEVICE_ADDR: local_byte = {4'h0, device_addr_r};
      `ACRB_LOC_CTRL_LOW: local_byte = {2'b00, supply_alarm_disable_r, input_alarm_disable_r, 1'b0,
        reset_pin_class_r, light_sleep_enable_r, shutdown_request_r};
      `ACRB_LOC_UNLOCK_KEY: local_byte = unlock_key_r;
      `ACRB_LOC_PROTOCOL: local_byte = {6'h00, write_protocol_select_r};
      default: local_byte = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (any_clear) begin
      local_byte_r <= 8'h00;
      from_store_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      local_byte_r <= local_byte;
      from_store_r <= rd_idx[5];
      rd_pend_r <= rd_en;
      rd_valid_r <= rd_pend_r;
      if (rd_pend_r) begin
        rd_data_r <= from_store_r ? store_rd_data : local_byte_r;
      end
    end
  end

endmodule

`default_nettype wire

// file: testbench/acrb_register_bank_props.sv
// Purpose: port checker for the register bank
// Assumes: one clock, srst is the power-on reset
// Notes: key_r shadows host key writes, cleared by any reset
`default_nettype none
module acrb_register_bank_props (
  input wire clk,
  input wire srst,
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire [5:0] rd_addr,
  input wire [7:0] rd_data_r,
  input wire rd_valid_r,
  input wire shutdown_request_r,
  input wire reset_pin_class_r,
  input wire [1:0] write_protocol_select_r,
  input wire clock_polarity_r,
  input wire clock_phase_r,
  input wire full_init_r,
  input wire app_reset_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------
  // checks
  // -----------------------------------------
  reg [7:0] key_r;
  wire ctl_wr = wr_en && wr_addr == 6'h04;
  always @(posedge clk) begin
    if (srst || app_reset_r || full_init_r) begin
      key_r <= 8'h00;
    end else if (wr_en && wr_addr == 6'h05) begin
      key_r <= wr_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_rd_latency: assert property (rd_en |-> ##2 rd_valid_r)
    else $error("read answer late");
  a_rd_cause: assert property (rd_valid_r |-> $past(rd_en, 2))
    else $error("read answer without request");
  a_unmapped_zero: assert property (rd_en && rd_addr >= 6'h2C |-> ##2 rd_data_r == 8'h00)
    else $error("unmapped byte not zero");
  a_key_guard: assert property (ctl_wr && key_r != 8'h69 |=> $stable(shutdown_request_r))
    else $error("locked control written");
  a_key_write: assert property (ctl_wr && key_r == 8'h69 |=> shutdown_request_r == $past(wr_data[0]))
    else $error("keyed write lost");
  a_proto_write: assert property (wr_en && wr_addr == 6'h08 |=>
    write_protocol_select_r == $past(wr_data[1:0]))
    else $error("protocol select wrong");
  // a pin reset clears select and polarity on the same edge, so skip while a reset is flagged
  a_pol_phase: assert property (!$past(srst) && !full_init_r && !app_reset_r |->
    {clock_polarity_r, clock_phase_r} == $past(write_protocol_select_r))
    else $error("polarity or phase wrong");
  a_class_sticky: assert property ($fell(reset_pin_class_r) |-> $past(srst))
    else $error("class bit cleared");
  a_full_init: assert property (disable iff (1'b0) srst |=> full_init_r)
    else $error("power-on reset not flagged");
  cover property (rd_valid_r);
  cover property (app_reset_r);
  cover property (ctl_wr && key_r == 8'h69);
endmodule
bind acrb_register_bank acrb_register_bank_props u_props (.clk(clk), .srst(srst), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
  .rd_valid_r(rd_valid_r), .shutdown_request_r(shutdown_request_r), .reset_pin_class_r(reset_pin_class_r),
  .write_protocol_select_r(write_protocol_select_r), .clock_polarity_r(clock_polarity_r),
  .clock_phase_r(clock_phase_r), .full_init_r(full_init_r), .app_reset_r(app_reset_r));
`default_nettype wire

// file: testbench/acrb_host_model.sv
// Purpose: host side of the byte register port
// Assumes: tasks are entered just after a rising edge
// Notes: idle lines carry random values so stale data never looks valid
`default_nettype none
module acrb_host_model (
  input wire logic clk,
  output logic wr_en,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [5:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------
  // host tasks
  // -----------------------------------------
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 6'h00;
    wr_data = 8'h00;
    rd_addr = 6'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    wr_addr <= a;
    wr_data <= v;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    rd_addr <= a;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    wr_addr <= 6'($urandom);
    wr_data <= 8'($urandom);
    rd_addr <= 6'($urandom);
    repeat (n) @(posedge clk);
  endtask
  task automatic prot_wr(input logic [7:0] v);
    wr(6'h05, 8'h69);
    wr(6'h04, v);
  endtask
endmodule
`default_nettype wire

// file: testbench/acrb_register_bank_tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model drives the byte port, bench drives the pins
// Notes: reads are checked in arrival order against a queue
`default_nettype none
module acrb_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------
  // signals and tasks
  // -----------------------------------------
  logic clk, srst, reset_pin_n, conversion_start_select, conversion_done;
  logic wr_en, rd_en, rd_valid_r, supply_alarm_disable_r, input_alarm_disable_r, reset_pin_class_r;
  logic light_sleep_enable_r, shutdown_request_r, clock_polarity_r, clock_phase_r, light_sleep_active_r;
  logic full_init_r, app_reset_r;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data_r, d, exp_rd;
  logic [3:0] device_addr_r;
  logic [1:0] write_protocol_select_r;
  logic [7:0] exp_q[$];
  logic [7:0] mem[24];
  logic [5:0] rsv[4] = '{6'h01, 6'h06, 6'h07, 6'h0B};
  int n_errors = 0;
  int tests_run = 0;
  acrb_register_bank u_acrb_register_bank (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n),
    .conversion_start_select(conversion_start_select), .conversion_done(conversion_done), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .device_addr_r(device_addr_r), .supply_alarm_disable_r(supply_alarm_disable_r),
    .input_alarm_disable_r(input_alarm_disable_r), .reset_pin_class_r(reset_pin_class_r),
    .light_sleep_enable_r(light_sleep_enable_r), .shutdown_request_r(shutdown_request_r),
    .write_protocol_select_r(write_protocol_select_r), .clock_polarity_r(clock_polarity_r),
    .clock_phase_r(clock_phase_r), .light_sleep_active_r(light_sleep_active_r), .full_init_r(full_init_r),
    .app_reset_r(app_reset_r));
  acrb_host_model u_acrb_host_model (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // sampled on the falling edge so the design's updates have landed
  task automatic chk_f(input logic [4:0] e);
    @(negedge clk);
    d = {3'h0, supply_alarm_disable_r, input_alarm_disable_r, reset_pin_class_r, light_sleep_enable_r,
      shutdown_request_r};
    chk("fields", {3'h0, e}, d);
    @(posedge clk);
  endtask
  task automatic rdx(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_acrb_host_model.rd(a);
  endtask
  task automatic pulse;
    conversion_done <= 1'b1;
    @(posedge clk);
    conversion_done <= 1'b0;
  endtask
  task automatic wait_sleep(input logic e);
    int k;
    @(negedge clk);
    for (k = 0; k < 8 && light_sleep_active_r !== e; k++) begin
      @(negedge clk);
    end
    chk("light_sleep_active_r", {7'h00, e}, {7'h00, light_sleep_active_r});
    if (k == 8) begin
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic pin_reset(input string n, input logic [7:0] e);
    reset_pin_n <= 1'b0;
    u_acrb_host_model.idle(6);
    @(negedge clk);
    chk(n, e, {6'h00, app_reset_r, full_init_r});
    @(posedge clk);
    reset_pin_n <= 1'b1;
    u_acrb_host_model.idle(6);
  endtask
  task automatic test_done;
    // a read that never answered is a mismatch too
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("[ERR] exp_q expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (rd_valid_r === 1'b1) begin
      exp_rd = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      chk("rd_data_r", exp_rd, rd_data_r);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  initial begin
    srst <= 1'b1;
    reset_pin_n <= 1'b1;
    conversion_start_select <= 1'b0;
    conversion_done <= 1'b0;
    void'($urandom(32'hBFEF2AED));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 48; a++) begin
      rdx(6'(a), 8'h00);
    end
    u_acrb_host_model.wr(6'h04, 8'h3F);
    u_acrb_host_model.idle(1);
    chk_f(5'h00);
    u_acrb_host_model.prot_wr(8'hFF);
    u_acrb_host_model.idle(1);
    chk_f(5'h1F);
    rdx(6'h04, 8'h37);
    rdx(6'h05, 8'h69);
    $display("test reset_and_key done");
    for (int i = 0; i < 24; i++) begin
      mem[i] = 8'($urandom);
      u_acrb_host_model.wr(6'(i < 12 ? 12 + i : 20 + i), mem[i]);
    end
    foreach (rsv[k]) begin
      u_acrb_host_model.wr(rsv[k], 8'hFF);
    end
    for (int i = 0; i < 24; i++) begin
      rdx(6'(i < 12 ? 12 + i : 20 + i), mem[i]);
    end
    foreach (rsv[k]) begin
      rdx(rsv[k], 8'h00);
    end
    $display("test byte_map done");
    // ending on code 00 keeps the serial mode plain for the reset tests
    for (int c = 3; c >= 0; c--) begin
      u_acrb_host_model.wr(6'h08, {6'($urandom), 2'(c)});
      u_acrb_host_model.idle(2);
      @(negedge clk);
      d = {4'h0, write_protocol_select_r, clock_polarity_r, clock_phase_r};
      chk("protocol", {4'h0, 2'(c), 2'(c)}, d);
      @(posedge clk);
      rdx(6'h08, {6'h00, 2'(c)});
    end
    u_acrb_host_model.wr(6'h02, 8'hA5);
    u_acrb_host_model.idle(1);
    @(negedge clk);
    chk("device_addr_r", 8'h05, {4'h0, device_addr_r});
    @(posedge clk);
    rdx(6'h02, 8'h05);
    $display("test protocol done");
    conversion_start_select <= 1'b1;
    u_acrb_host_model.idle(4);
    pulse();
    wait_sleep(1'b1);
    conversion_start_select <= 1'b0;
    wait_sleep(1'b0);
    u_acrb_host_model.prot_wr(8'h00);
    u_acrb_host_model.idle(1);
    chk_f(5'h04);
    conversion_start_select <= 1'b1;
    u_acrb_host_model.idle(4);
    pulse();
    u_acrb_host_model.idle(4);
    wait_sleep(1'b0);
    $display("test sleep done");
    u_acrb_host_model.prot_wr(8'h33);
    u_acrb_host_model.wr(6'h0C, 8'h5A);
    pin_reset("app_reset", 8'h02);
    chk_f(5'h06);
    rdx(6'h0C, 8'h00);
    u_acrb_host_model.idle(4);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    u_acrb_host_model.idle(4);
    chk_f(5'h00);
    pin_reset("full_init", 8'h01);
    $display("test resets done");
    test_done();
  end
endmodule
`default_nettype wire
